// ==== inc/pci_link_pkg.sv ====
/*
 * Shared constants and carrier types for the PCI bus-side control block:
 * master state codes, termination codes, the master request record and
 * the timing counts used by the bus logic.
 * Assumes a single core clock at 100 MHz that also times the bus pins.
 */
package pci_link_pkg;

  // Core clock period in picoseconds; 100 MHz.
  localparam int unsigned CLK_PERIOD_PS = 10000;

  // Bus, length and select counter widths.
  localparam int unsigned AD_W  = 32;
  localparam int unsigned CBE_W = 4;
  localparam int unsigned LEN_W = 8;
  localparam int unsigned DEV_W = 3;

  // Clocks without a device select before the master gives up.
  localparam logic [DEV_W-1:0] DEVSEL_TIMEOUT = 3'h5;

  // Reset values of the bus drivers (every output released), then the length and select count constants.
  localparam logic [AD_W-1:0]  AD_RESET  = 32'h0000_0000;
  localparam logic [CBE_W-1:0] CBE_RESET = 4'hf;
  localparam logic [LEN_W-1:0] LEN_ONE   = 8'h01;
  localparam logic [LEN_W-1:0] LEN_ZERO  = 8'h00;
  localparam logic [DEV_W-1:0] DEV_ZERO  = 3'h0;
  localparam logic [DEV_W-1:0] DEV_STEP  = 3'h1;

  // Master sequencer states, one-hot.
  typedef enum logic [5:0] {
    M_IDLE = 6'b000001,
    M_REQ  = 6'b000010,
    M_ADDR = 6'b000100,
    M_DATA = 6'b001000,
    M_LAST = 6'b010000,
    M_TURN = 6'b100000
  } mstate_t;

  // How a master transaction ended.
  typedef enum logic [2:0] {
    TERM_OK     = 3'h0,
    TERM_DISC   = 3'h1,
    TERM_RETRY  = 3'h2,
    TERM_TABORT = 3'h3,
    TERM_MABORT = 3'h4
  } term_t;

  // One master request from the user side.
  typedef struct packed {
    logic [AD_W-1:0]  addr;
    logic [CBE_W-1:0] cmd;
    logic             write;
    logic [AD_W-1:0]  wdata;
    logic [LEN_W-1:0] len;
  } mreq_t;

endpackage : pci_link_pkg

// ==== hw/pci_bus_ctrl.sv ====
/*
 * Device-side PCI bus control: reset release of all pins, address parity
 * monitoring with system error signalling, even parity generation and
 * read data parity checking, and a burst master that honours target
 * stop, wait states and device select timeout.
 * Assumes all bus inputs are synchronous to core_clk, that pins are
 * resolved outside from the output enables, and that the host keeps
 * rst_n low long enough.
 */
`timescale 1ns/1ps

module pci_bus_ctrl (
  input  wire logic                               core_clk,
  input  wire logic                               rst_n,
  input  wire logic [pci_link_pkg::AD_W-1:0]      ad_in,
  output logic      [pci_link_pkg::AD_W-1:0]      ad_out_q,
  output logic                                    ad_oe_q,
  input  wire logic [pci_link_pkg::CBE_W-1:0]     command_byte_enable_n_in,
  output logic      [pci_link_pkg::CBE_W-1:0]     command_byte_enable_n_out_q,
  output logic                                    command_byte_enable_n_oe_q,
  input  wire logic                               par_in,
  output logic                                    par_out_q,
  output logic                                    par_oe_q,
  input  wire logic                               frame_n_in,
  output logic                                    frame_n_out_q,
  output logic                                    frame_n_oe_q,
  input  wire logic                               irdy_n_in,
  output logic                                    irdy_n_out_q,
  output logic                                    irdy_n_oe_q,
  input  wire logic                               trdy_n_in,
  input  wire logic                               stop_n_in,
  input  wire logic                               devsel_n_in,
  input  wire logic                               serr_n_in,
  output logic                                    serr_n_out_q,
  output logic                                    serr_n_oe_q,
  output logic                                    req_n_q,
  input  wire logic                               gnt_n,
  input  wire logic                               serr_check_en,
  input  wire logic                               sys_err_clr,
  output logic                                    sys_err_status_q,
  output logic                                    sig_sys_err_q,
  input  wire logic                               mreq_valid,
  input  wire pci_link_pkg::mreq_t                mreq,
  output logic                                    mreq_ready_q,
  input  wire logic [pci_link_pkg::AD_W-1:0]      next_wdata,
  output logic                                    phase_done_q,
  output logic      [pci_link_pkg::AD_W-1:0]      rdata_q,
  output logic                                    xfer_done_q,
  output pci_link_pkg::term_t                     xfer_term_q
);

  // Even parity bit over one address or data phase.
  function automatic logic even_par(input logic [pci_link_pkg::AD_W-1:0] ad,
                                    input logic [pci_link_pkg::CBE_W-1:0] cbe);
    even_par = ^{ad, cbe};
  endfunction : even_par

  pci_link_pkg::mstate_t                  st_q, st_d;
  pci_link_pkg::mreq_t                    cur_q;
  logic [pci_link_pkg::LEN_W-1:0]         left_q, left_d;
  logic [pci_link_pkg::DEV_W-1:0]         dev_cnt_q;
  logic                                   any_done_q;
  logic                                   frame_prev_q;
  logic                                   addr_chk_q;
  logic                                   addr_par_q;
  logic                                   rd_chk_q;
  logic                                   rd_par_q;

  // Decoded bus conditions, all taken from values sampled at the edge.
  wire in_data    = (st_q == pci_link_pkg::M_DATA) || (st_q == pci_link_pkg::M_LAST);
  wire ph_done    = in_data && !irdy_n_in && !trdy_n_in;
  wire tgt_stop   = in_data && !stop_n_in;
  wire tgt_abort  = tgt_stop && devsel_n_in && trdy_n_in;
  wire mst_abort  = in_data && devsel_n_in && (dev_cnt_q == pci_link_pkg::DEVSEL_TIMEOUT);
  wire last_word  = ph_done && (left_q == pci_link_pkg::LEN_ONE);
  // A transfer ends on the step into turnaround, so a stop that needs an extra
  // phase with FRAME high is reported once and not twice.
  wire xfer_end   = in_data && (st_d == pci_link_pkg::M_TURN);
  wire addr_phase = frame_prev_q && !frame_n_in;
  wire addr_perr  = addr_chk_q && (par_in != addr_par_q);
  wire data_perr  = rd_chk_q && (par_in != rd_par_q);
  wire can_start  = mreq_valid && mreq_ready_q;
  wire bus_free   = !gnt_n && frame_n_in && irdy_n_in;

  // Termination code; abort outranks stop, and retry means no word moved.
  pci_link_pkg::term_t term_d;
  assign term_d = mst_abort ? pci_link_pkg::TERM_MABORT :
                  tgt_abort ? pci_link_pkg::TERM_TABORT :
                  (tgt_stop && !ph_done && !any_done_q) ? pci_link_pkg::TERM_RETRY :
                  tgt_stop ? pci_link_pkg::TERM_DISC : pci_link_pkg::TERM_OK;

  // Next state and word count of the master sequencer.
  always_comb begin
    st_d   = st_q;
    left_d = left_q;
    case (st_q)
      pci_link_pkg::M_IDLE: begin
        if (can_start) begin
          st_d   = pci_link_pkg::M_REQ;
          left_d = (mreq.len == pci_link_pkg::LEN_ZERO) ? pci_link_pkg::LEN_ONE : mreq.len;
        end
      end
      pci_link_pkg::M_REQ: begin
        if (bus_free) begin
          st_d = pci_link_pkg::M_ADDR;
        end
      end
      pci_link_pkg::M_ADDR: begin
        st_d = pci_link_pkg::M_DATA;
      end
      pci_link_pkg::M_DATA: begin
        if (ph_done) begin
          left_d = left_q - pci_link_pkg::LEN_ONE;
        end
        // Frame must rise before IRDY releases, so a stop mid burst takes a last phase.
        if (last_word || mst_abort || (tgt_stop && frame_n_out_q)) begin
          st_d = pci_link_pkg::M_TURN;
        end else if (tgt_stop) begin
          st_d = pci_link_pkg::M_LAST;
        end
      end
      pci_link_pkg::M_LAST: begin
        st_d = pci_link_pkg::M_TURN;
      end
      pci_link_pkg::M_TURN: begin
        st_d = pci_link_pkg::M_IDLE;
      end
      default: begin
        st_d = pci_link_pkg::M_IDLE;
      end
    endcase
  end

  // Sequencer registers; reset forces idle with no request pending.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q   <= pci_link_pkg::M_IDLE;
      left_q <= pci_link_pkg::LEN_ZERO;
      cur_q  <= '0;
    end else begin
      st_q   <= st_d;
      left_q <= left_d;
      if (can_start) begin
        cur_q <= mreq;
      end
    end
  end

  // Master pin drivers; every enable drops in reset so the bus floats.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ad_oe_q                     <= 1'b0;
      ad_out_q                    <= pci_link_pkg::AD_RESET;
      command_byte_enable_n_oe_q  <= 1'b0;
      command_byte_enable_n_out_q <= pci_link_pkg::CBE_RESET;
      frame_n_oe_q                <= 1'b0;
      frame_n_out_q               <= 1'b1;
      irdy_n_oe_q                 <= 1'b0;
      irdy_n_out_q                <= 1'b1;
      req_n_q                     <= 1'b1;
    end else begin
      req_n_q <= !((st_d == pci_link_pkg::M_REQ) || (st_d == pci_link_pkg::M_ADDR));
      case (st_d)
        pci_link_pkg::M_ADDR: begin
          ad_oe_q                     <= 1'b1;
          ad_out_q                    <= cur_q.addr;
          command_byte_enable_n_oe_q  <= 1'b1;
          command_byte_enable_n_out_q <= cur_q.cmd;
          frame_n_oe_q                <= 1'b1;
          frame_n_out_q               <= 1'b0;
          irdy_n_oe_q                 <= 1'b1;
          irdy_n_out_q                <= 1'b1;
        end
        pci_link_pkg::M_DATA, pci_link_pkg::M_LAST: begin
          // Reads turn AD around; writes present the current word.
          ad_oe_q                     <= cur_q.write;
          if (st_q == pci_link_pkg::M_ADDR) begin
            ad_out_q <= cur_q.wdata;
          end else if (ph_done) begin
            ad_out_q <= next_wdata;
          end
          command_byte_enable_n_out_q <= {pci_link_pkg::CBE_W{1'b0}};
          frame_n_out_q               <= (st_d == pci_link_pkg::M_LAST) ||
                                         (left_d == pci_link_pkg::LEN_ONE);
          irdy_n_out_q                <= 1'b0;
        end
        pci_link_pkg::M_TURN: begin
          ad_oe_q                     <= 1'b0;
          command_byte_enable_n_oe_q  <= 1'b0;
          frame_n_out_q               <= 1'b1;
          irdy_n_out_q                <= 1'b1;
        end
        default: begin
          ad_oe_q                     <= 1'b0;
          command_byte_enable_n_oe_q  <= 1'b0;
          frame_n_oe_q                <= 1'b0;
          frame_n_out_q               <= 1'b1;
          irdy_n_oe_q                 <= 1'b0;
          irdy_n_out_q                <= 1'b1;
        end
      endcase
    end
  end

  // Parity trails the phase it covers by one clock, as the bus expects.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      par_oe_q  <= 1'b0;
      par_out_q <= 1'b0;
    end else begin
      par_oe_q  <= ad_oe_q;
      par_out_q <= even_par(ad_out_q, command_byte_enable_n_out_q);
    end
  end

  // Device select timeout and per-phase user handshake.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dev_cnt_q    <= pci_link_pkg::DEV_ZERO;
      any_done_q   <= 1'b0;
      phase_done_q <= 1'b0;
      rdata_q      <= pci_link_pkg::AD_RESET;
      xfer_done_q  <= 1'b0;
      xfer_term_q  <= pci_link_pkg::TERM_OK;
    end else begin
      dev_cnt_q    <= (in_data && devsel_n_in && !mst_abort) ?
                      dev_cnt_q + pci_link_pkg::DEV_STEP : pci_link_pkg::DEV_ZERO;
      any_done_q   <= in_data && (any_done_q || ph_done);
      phase_done_q <= ph_done;
      if (ph_done && !cur_q.write) begin
        rdata_q <= ad_in;
      end
      xfer_done_q  <= xfer_end;
      if (xfer_end) begin
        xfer_term_q <= term_d;
      end
    end
  end

  // Parity checks: address phases of any agent, read data for our master.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      frame_prev_q <= 1'b1;
      addr_chk_q   <= 1'b0;
      addr_par_q   <= 1'b0;
      rd_chk_q     <= 1'b0;
      rd_par_q     <= 1'b0;
    end else begin
      frame_prev_q <= frame_n_in;
      addr_chk_q   <= addr_phase;
      addr_par_q   <= even_par(ad_in, command_byte_enable_n_in);
      rd_chk_q     <= ph_done && !cur_q.write;
      rd_par_q     <= even_par(ad_in, command_byte_enable_n_in);
    end
  end

  // System error pulse lands two clocks after the bad address phase.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      serr_n_oe_q   <= 1'b0;
      serr_n_out_q  <= 1'b0;
      sig_sys_err_q <= 1'b0;
    end else begin
      serr_n_oe_q   <= addr_perr && serr_check_en;
      serr_n_out_q  <= 1'b0;
      sig_sys_err_q <= (addr_perr && serr_check_en) || sig_sys_err_q;
    end
  end

  // The halt flag blocks new requests only; the running burst completes.
  // A new error in the clearing cycle wins so none is lost.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sys_err_status_q <= 1'b0;
      mreq_ready_q     <= 1'b0;
    end else begin
      sys_err_status_q <= data_perr || (sys_err_status_q && !sys_err_clr);
      mreq_ready_q     <= (st_d == pci_link_pkg::M_IDLE) && !can_start &&
                          !data_perr && !(sys_err_status_q && !sys_err_clr);
    end
  end

endmodule : pci_bus_ctrl

// ==== tb/pci_bus_checker.sv ====
/* Concurrent checks on the PCI bus control ports.
   Assumes the bus inputs carry the resolved pin levels. */
`timescale 1ns/1ps
module pci_bus_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [31:0] ad_in,
  input wire logic [3:0]  command_byte_enable_n_in,
  input wire logic        par_in,
  input wire logic        frame_n_in,
  input wire logic        irdy_n_in,
  input wire logic        trdy_n_in,
  input wire logic        stop_n_in,
  input wire logic        gnt_n,
  input wire logic        serr_check_en,
  input wire logic [31:0] ad_out_q,
  input wire logic [3:0]  command_byte_enable_n_out_q,
  input wire logic        ad_oe_q,
  input wire logic        command_byte_enable_n_oe_q,
  input wire logic        par_out_q,
  input wire logic        par_oe_q,
  input wire logic        frame_n_oe_q,
  input wire logic        irdy_n_oe_q,
  input wire logic        serr_n_oe_q,
  input wire logic        req_n_q,
  input wire logic        sig_sys_err_q,
  input wire logic        phase_done_q,
  input wire logic        xfer_done_q,
  input wire logic        mreq_ready_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Any pin driver switched on.
  wire any_oe = ad_oe_q | command_byte_enable_n_oe_q | par_oe_q | frame_n_oe_q
              | irdy_n_oe_q | serr_n_oe_q;

  // An address phase whose parity check fails while checking is enabled.
  sequence s_addr_bad;
    frame_n_in ##1 !frame_n_in
    ##1 (serr_check_en && par_in != ^{$past(ad_in), $past(command_byte_enable_n_in)});
  endsequence
  // A data phase of our own that completes.
  sequence s_beat;
    irdy_n_oe_q && !irdy_n_in && !trdy_n_in;
  endsequence

  a_reset_floats: assert property (disable iff (1'b0) !rst_n
      |=> !any_oe && req_n_q)
    else $error("pins driven during reset");
  a_serr_timing: assert property (s_addr_bad |=> serr_n_oe_q && sig_sys_err_q)
    else $error("system error late or missing");
  a_serr_cause: assert property (serr_n_oe_q |-> $past(serr_check_en)
      && !$past(frame_n_in, 2) && $past(frame_n_in, 3))
    else $error("system error without address cause");
  a_serr_pulse: assert property (serr_n_oe_q |=> !serr_n_oe_q)
    else $error("system error held too long");
  a_sig_sticky: assert property (sig_sys_err_q |=> sig_sys_err_q)
    else $error("signalled error flag lost");
  a_par_even: assert property (par_oe_q |-> $past(ad_oe_q)
      && par_out_q == ^{$past(ad_out_q), $past(command_byte_enable_n_out_q)})
    else $error("parity wrong");
  a_beat_done: assert property (s_beat |=> phase_done_q)
    else $error("completed phase not reported");
  a_done_cause: assert property (phase_done_q
      |-> !$past(irdy_n_in) && !$past(trdy_n_in))
    else $error("phase reported without both ready");
  a_stop_ends: assert property (irdy_n_oe_q && !irdy_n_in && !stop_n_in
      |-> ##[1:6] xfer_done_q)
    else $error("stop not honoured");
  a_done_pulse: assert property (xfer_done_q |=> !xfer_done_q)
    else $error("transfer end reported twice");
  a_grant_first: assert property ($rose(frame_n_oe_q)
      |-> !$past(gnt_n) && $past(frame_n_in) && $past(irdy_n_in))
    else $error("bus taken without grant");
  a_idle_start: assert property ($rose(rst_n) |-> req_n_q ##1 mreq_ready_q)
    else $error("not idle after reset");
  c_serr: cover property (s_addr_bad);
endmodule : pci_bus_checker

bind pci_bus_ctrl pci_bus_checker pci_bus_checker_i (.core_clk, .rst_n, .ad_in,
  .command_byte_enable_n_in, .par_in, .frame_n_in, .irdy_n_in, .trdy_n_in, .stop_n_in,
  .gnt_n, .serr_check_en, .ad_out_q, .command_byte_enable_n_out_q, .ad_oe_q,
  .command_byte_enable_n_oe_q, .par_out_q, .par_oe_q, .frame_n_oe_q, .irdy_n_oe_q,
  .serr_n_oe_q, .req_n_q, .sig_sys_err_q, .phase_done_q, .xfer_done_q, .mreq_ready_q);

// ==== tb/pci_target_model.sv ====
/* Behavioural arbiter and target for the far side of the bus.
   Assumes resolved pin levels; mode 0 ok, 1 retry, 2 disconnect,
   3 target abort, 4 no device select. */
`timescale 1ns/1ps
module pci_target_model #(
  parameter logic [31:0] RD_BASE = 32'h5a00_0000
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        req_n,
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic [31:0] ad,
  input  wire logic [3:0]  cbe_n,
  input  wire logic [2:0]  mode,
  input  wire logic [3:0]  waits,
  input  wire logic        bad_par,
  output logic             gnt_n,
  output logic             devsel_n,
  output logic             trdy_n,
  output logic             stop_n,
  output logic             ad_oe,
  output logic      [31:0] ad_drv,
  output logic             par_oe,
  output logic             par_drv,
  output logic      [31:0] wr_word
);
  logic       frame_q, active_q, rd_q;
  logic [3:0] cnt_q;
  logic [7:0] n_q;

  // Ready only after the wait count; a released bus shows the inverse word.
  wire go = active_q && !irdy_n && cnt_q == 4'h0;
  assign devsel_n = !(active_q && mode != 3'h3);
  assign trdy_n   = !(go && (mode == 3'h0 || (mode == 3'h2 && n_q == 8'h00)));
  assign stop_n   = !(go && mode != 3'h0);
  assign ad_oe    = active_q && rd_q;
  assign ad_drv   = ad_oe ? RD_BASE + 32'(n_q) : ~(RD_BASE + 32'(n_q));

  // Grant follows request a cycle later; a phase moves a word on both ready.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gnt_n    <= 1'b1;
      frame_q  <= 1'b1;
      active_q <= 1'b0;
      par_oe   <= 1'b0;
    end else begin
      gnt_n   <= req_n;
      frame_q <= frame_n;
      par_oe  <= ad_oe;
      par_drv <= ^{ad, cbe_n} ^ bad_par;
      if (frame_q && !frame_n) begin
        active_q <= mode != 3'h4;
        rd_q     <= !cbe_n[0];
        cnt_q    <= waits;
        n_q      <= 8'h00;
      end else if (frame_n && irdy_n) begin
        active_q <= 1'b0;
      end else if (!irdy_n && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (!irdy_n && !trdy_n) begin
        n_q     <= n_q + 8'h01;
        cnt_q   <= waits;
        wr_word <= ad;
      end
    end
  end
endmodule : pci_target_model

// ==== tb/tb_top.sv ====
/* Self-checking bench for the PCI bus control block.
   Assumes the target model answers every master cycle outside mode 4. */
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] RD_BASE = 32'h5a00_0000;
  localparam logic [31:0] W0      = 32'hc3c3_0000;
  logic core_clk, rst_n, serr_check_en, sys_err_clr, mreq_valid, m_on, m_frame_n, m_par;
  logic bad_par, ad_oe_q, cbe_oe_q, par_out_q, par_oe_q, frame_n_out_q, frame_n_oe_q;
  logic irdy_n_out_q, irdy_n_oe_q, serr_n_out_q, serr_n_oe_q, req_n_q, gnt_n, trdy_n;
  logic stop_n, devsel_n, t_ad_oe, t_par_oe, t_par, sys_err_status_q, sig_sys_err_q;
  logic mreq_ready_q, phase_done_q, xfer_done_q;
  logic [31:0]         next_wdata, m_ad, ad_out_q, t_ad, t_wr, rdata_q;
  logic [3:0]          m_cbe, waits, cbe_out_q;
  logic [2:0]          mode;
  pci_link_pkg::term_t xfer_term_q;
  pci_link_pkg::mreq_t mreq;
  int                  mismatches, num_checks, np;

  // Pin resolution: pull-ups on control lines, inverse data when released.
  wire [31:0] ad_in      = ad_oe_q ? ad_out_q : m_on ? m_ad : t_ad;
  wire [3:0]  cbe_in     = cbe_oe_q ? cbe_out_q : m_on ? m_cbe : ~cbe_out_q;
  wire        par_in     = par_oe_q ? par_out_q : m_on ? m_par : t_par_oe ? t_par : ~par_out_q;
  wire        frame_n_in = frame_n_oe_q ? frame_n_out_q : !m_on | m_frame_n;
  wire        irdy_n_in  = !irdy_n_oe_q | irdy_n_out_q;
  wire        serr_n_in  = !serr_n_oe_q | serr_n_out_q;

  // Free-running core clock.
  always #5 core_clk = ~core_clk;

  pci_bus_ctrl pci_bus_ctrl_i (.core_clk, .rst_n, .ad_in, .ad_out_q, .ad_oe_q,
    .command_byte_enable_n_in(cbe_in), .command_byte_enable_n_out_q(cbe_out_q),
    .command_byte_enable_n_oe_q(cbe_oe_q), .par_in, .par_out_q, .par_oe_q, .frame_n_in,
    .frame_n_out_q, .frame_n_oe_q, .irdy_n_in, .irdy_n_out_q, .irdy_n_oe_q,
    .trdy_n_in(trdy_n), .stop_n_in(stop_n), .devsel_n_in(devsel_n), .serr_n_in,
    .serr_n_out_q, .serr_n_oe_q, .req_n_q, .gnt_n, .serr_check_en, .sys_err_clr,
    .sys_err_status_q, .sig_sys_err_q, .mreq_valid, .mreq, .mreq_ready_q, .next_wdata,
    .phase_done_q, .rdata_q, .xfer_done_q, .xfer_term_q);

  pci_target_model #(.RD_BASE(RD_BASE)) pci_target_model_i (.core_clk, .rst_n,
    .req_n(req_n_q), .frame_n(frame_n_in), .irdy_n(irdy_n_in), .ad(ad_in), .cbe_n(cbe_in),
    .mode, .waits, .bad_par, .gnt_n, .devsel_n, .trdy_n, .stop_n, .ad_oe(t_ad_oe),
    .ad_drv(t_ad), .par_oe(t_par_oe), .par_drv(t_par), .wr_word(t_wr));

  task automatic tick; @(posedge core_clk); #1; endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Reset is held well beyond the ten-clock minimum the host must give.
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (16) tick;
    chk({29'h0, ad_oe_q, cbe_oe_q, par_oe_q}, 0);
    chk({29'h0, frame_n_oe_q, irdy_n_oe_q, serr_n_oe_q}, 0);
    chk(req_n_q, 1);
    rst_n = 1'b1;
    tick;
    chk(mreq_ready_q, 1);
  endtask : do_reset

  // One master transfer; read words are compared as they complete.
  task automatic run(input logic wr, input logic [7:0] len, input logic [2:0] md,
                     input logic [3:0] wt);
    int k;
    mode = md;
    waits = wt;
    mreq = '{addr: 32'h0000_1000, cmd: {3'h3, wr}, write: wr, wdata: W0, len: len};
    next_wdata = W0 + 32'h1;
    for (k = 0; k < 50 && mreq_ready_q !== 1'b1; k++) tick;
    mreq_valid = 1'b1;
    tick;
    mreq_valid = 1'b0;
    np = 0;
    for (k = 0; k < 300; k++) begin
      tick;
      if (phase_done_q === 1'b1) begin
        if (!wr) chk(rdata_q, RD_BASE + 32'(np));
        np++;
        next_wdata = W0 + 32'(np) + 32'h1;
      end
      if (xfer_done_q === 1'b1) break;
    end
    chk(xfer_done_q, 1);
  endtask : run

  task automatic t_bursts;
    run(1'b0, 8'h04, 3'h0, 4'h2);
    chk(np, 4);
    chk(xfer_term_q, pci_link_pkg::TERM_OK);
    run(1'b1, 8'h03, 3'h0, 4'h0);
    chk(np, 3);
    chk(t_wr, W0 + 32'h2);
  endtask : t_bursts

  // Each target stop flavour and the missing select, with words moved.
  task automatic t_stop_codes;
    pci_link_pkg::term_t exp_t[4];
    int exp_n[4];
    exp_t = '{pci_link_pkg::TERM_RETRY, pci_link_pkg::TERM_DISC,
              pci_link_pkg::TERM_TABORT, pci_link_pkg::TERM_MABORT};
    exp_n = '{0, 1, 0, 0};
    for (int i = 0; i < 4; i++) begin
      run(1'b0, 8'h04, 3'(i + 1), 4'h0);
      chk(xfer_term_q, exp_t[i]);
      chk(np, exp_n[i]);
    end
  endtask : t_stop_codes

  // Another master puts out an address with bad parity; disabled, then enabled.
  task automatic t_addr_parity;
    for (int en = 0; en < 2; en++) begin
      serr_check_en = en[0];
      mode = 3'h4;
      // Our own turnaround still drives FRAME high; wait until it lets go.
      repeat (2) tick;
      m_on = 1'b1;
      m_frame_n = 1'b0;
      tick;
      m_frame_n = 1'b1;
      m_par = ~^{m_ad, m_cbe};
      tick;
      chk(serr_n_oe_q, en[0]);
      chk(serr_n_in, !en[0]);
      chk(sig_sys_err_q, en[0]);
      tick;
      m_on = 1'b0;
      chk(serr_n_oe_q, 0);
      tick;
    end
  endtask : t_addr_parity

  // Bad read parity: burst completes, then requests stay refused until cleared.
  task automatic t_data_parity;
    bad_par = 1'b1;
    run(1'b0, 8'h02, 3'h0, 4'h0);
    bad_par = 1'b0;
    repeat (3) tick;
    chk(np, 2);
    chk(sys_err_status_q, 1);
    chk(mreq_ready_q, 0);
    sys_err_clr = 1'b1;
    tick;
    sys_err_clr = 1'b0;
    repeat (2) tick;
    chk(sys_err_status_q, 0);
    chk(mreq_ready_q, 1);
  endtask : t_data_parity

  // Reset lands while a slow read waits on the target.
  task automatic t_mid_reset;
    mode = 3'h0;
    waits = 4'hf;
    for (int k = 0; k < 50 && mreq_ready_q !== 1'b1; k++) tick;
    mreq_valid = 1'b1;
    tick;
    mreq_valid = 1'b0;
    repeat (6) tick;
    do_reset;
  endtask : t_mid_reset

  // Main sequence; every input has a value at time zero.
  initial begin
    {core_clk, serr_check_en, sys_err_clr, mreq_valid, m_on, bad_par} = '0;
    {m_frame_n, m_par, rst_n} = 3'h6;
    {next_wdata, mode, waits} = '0;
    m_ad = 32'h0000_2040;
    m_cbe = 4'h6;
    mreq = '0;
    mismatches = 0;
    num_checks = 0;
    do_reset;
    t_bursts;
    t_stop_codes;
    t_addr_parity;
    t_data_parity;
    t_mid_reset;
    wrap_up;
  end

  // Watchdog: the whole run needs well under a thousand cycles.
  initial begin
    #50000;
    mismatches++;
    wrap_up;
  end
endmodule : tb_top
